// ==== lcd_bus_cfg.svh ====
// Constants for the character display host port: offsets, fields, instruction decode, timing.
// Assumes inclusion by bare name from package and modules alike.
`ifndef LCD_BUS_CFG_SVH
`define LCD_BUS_CFG_SVH

// Register byte offsets
`define REG_CTRL 4'h0
`define REG_STAT 4'h4
`define REG_CURS 4'h8
`define REG_INIT 4'hc

// Control register fields
`define CTRL_INIT_BIT 0

// Status register fields
`define STAT_NIBBLE_BIT 0
`define STAT_HALF_BIT 1
`define STAT_DISP_BIT 2
`define STAT_CURS_BIT 3
`define STAT_ICON_BIT 4
`define STAT_PDOWN_BIT 5
`define STAT_BUSY_BIT 6
`define STAT_INCR_BIT 7
`define STAT_SHIFT_BIT 8
`define STAT_GLYPH_BIT 9
`define STAT_TWOLINE_BIT 10
`define STAT_VREG_BIT 11

// Instruction decode
`define CMD_FUNC_MASK 8'he0
`define CMD_FUNC_VAL 8'h20
`define CMD_DISP_MASK 8'hf8
`define CMD_DISP_VAL 8'h08
`define CMD_ENTRY_MASK 8'hfc
`define CMD_ENTRY_VAL 8'h04
`define CMD_GLYPH_MASK 8'hc0
`define CMD_GLYPH_VAL 8'h40
`define CMD_TEXT_MASK 8'h80
`define CMD_TEXT_VAL 8'h80
`define FUNC_WIDE_BIT 4
`define FUNC_LINES_BIT 2
`define FUNC_ICON_BIT 1
`define FUNC_VREG_BIT 0
`define DISP_ON_BIT 2
`define DISP_CURS_BIT 1
`define ENTRY_INC_BIT 1
`define ENTRY_SHIFT_BIT 0

// Memory and timing
`define TEXT_DEPTH 80
`define GLYPH_DEPTH 128
`define CLK_PERIOD_NS 100
`define INIT_TIME_NS 2000
`define INIT_CYCLES ((`INIT_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ==== lcd_bus_pkg.sv ====
// Types shared by the host port and its pin capture.
// Assumes lcd_bus_cfg.svh is on the include path.
package lcd_bus_pkg;
  typedef enum logic [1:0] {ST_INIT, ST_READY, ST_PDOWN} mode_t;

  typedef struct packed {
    logic register_select_line;
    logic rd_wr;
    logic [3:0] upper;
    logic [3:0] lower;
  } bus_word_t;

  typedef struct packed {
    logic valid;
    logic register_select_line;
    logic rd_wr;
    logic [7:0] data;
  } bus_xfer_t;

  typedef struct packed {
    logic display_on;
    logic cursor_on;
    logic icon_only_select;
    logic two_line;
    logic vreg_sel;
    logic incr;
    logic shift;
  } disp_cfg_t;
endpackage : lcd_bus_pkg

// ==== lcd_pin_sync.sv ====
// Pin capture for the parallel bus: two-stage synchronisers and strobe edge.
// Assumes the enable strobe is slower than three clock periods.
`timescale 1ns/100ps
module lcd_pin_sync
  import lcd_bus_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic en_pin,
  input wire logic pdown_pin,
  input wire bus_word_t pins,
  output bus_xfer_t xfer,
  output logic pdown
);
  typedef struct packed {
    logic [2:0] en;
    logic [1:0] pd;
    bus_word_t w1;
    bus_word_t w2;
    bus_xfer_t x;
  } sync_t;

  sync_t s_q, s_d;

  always_comb begin
    s_d = s_q;
    s_d.en = {s_q.en[1:0], en_pin};
    s_d.pd = {s_q.pd[0], pdown_pin};
    s_d.w1 = pins;
    s_d.w2 = s_q.w1;
    s_d.x.valid = 1'b0;
    // Latch on falling enable, data held stable there
    if (s_q.en[2] && !s_q.en[1]) begin
      s_d.x.valid = 1'b1;
      s_d.x.register_select_line = s_q.w2.register_select_line;
      s_d.x.rd_wr = s_q.w2.rd_wr;
      s_d.x.data = {s_q.w2.upper, s_q.w2.lower};
    end
    if (srst) begin
      s_d = '0;
    end
  end

  always_ff @(posedge clk) begin
    s_q <= s_d;
  end

  assign xfer = s_q.x;
  assign pdown = s_q.pd[1];
endmodule : lcd_pin_sync

// ==== lcd_nibble_bus_init.sv ====
// Host parallel port of a character display controller with Avalon-MM status access.
// Assumes pins are asynchronous to CLOCK; one clock domain, synchronous reset.
//
// Function
// R01: Bus starts eight lines wide after reset until configured.
// R02: First write after reset is taken whole from eight lines.
// R03: Nibble request is one write: upper 0010, select and rd_wr low.
// R04: Host repeats the upper configuration half; lower lines left open.
// R05: In nibble mode each transfer is two accesses, upper half first.
// R06: Second configuration nibble 0000 gives one line, first voltage register.
// R07: Display control 0000 1110 turns display and cursor on, screen blank.
// R08: Entry 0000 0110 makes writes increment address, cursor right, no shift.
// R09: Select-high write stores into text memory then advances cursor.
// R10: Icon-only bit switches character mode to icon mode.
// R11: Clearing display enable turns display off.
// R12: Power-down pin enters power-down from any mode.
// R13: A half-transfer toggle, cleared by reset, tracks nibble position.
// R14: Host waits for reset-time initialisation before commanding.
`timescale 1ns/100ps
`include "lcd_bus_cfg.svh"
module lcd_nibble_bus_init
  import lcd_bus_pkg::*;
#(
  parameter int TEXT_DEPTH = `TEXT_DEPTH,
  parameter int GLYPH_DEPTH = `GLYPH_DEPTH,
  parameter int INIT_CYCLES = `INIT_CYCLES
)
(
  input wire logic CLOCK,
  input wire logic SRST,
  input wire logic ENABLE_PIN,
  input wire logic REGISTER_SELECT_LINE,
  input wire logic RD_WR,
  input wire logic [7:0] BUS_LINES,
  input wire logic POWER_DOWN_PIN,
  output logic [7:0] BUS_LINES_OUT,
  output logic [7:0] BUS_LINES_OE,
  output logic DISPLAY_ON,
  output logic ICON_MODE,
  output logic POWER_DOWN,
  input wire logic [3:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST
);

  // ------------------------------------------------------------
  // Types and state
  // ------------------------------------------------------------
  typedef struct packed {
    mode_t mode;
    logic nibble_mode;
    logic half;
    logic [3:0] upper_held;
    logic first_done;
    disp_cfg_t cfg;
    logic glyph_sel;
    logic [6:0] addr;
    logic [15:0] init_cnt;
    logic [7:0] rd_data;
    logic [7:0] last_text;
    logic ack;
    logic [31:0] readdata;
  } state_t;

  state_t r_q, r_d;
  bus_xfer_t xfer;
  logic pdown;
  logic [7:0] text_mem [TEXT_DEPTH];
  logic [7:0] glyph_mem [GLYPH_DEPTH];
  logic cmd_valid;
  logic [7:0] cmd_byte;
  logic cmd_rs;
  logic mem_we;
  logic [6:0] mem_addr;
  logic [7:0] mem_wdata;
  logic mem_glyph;

  lcd_pin_sync lcd_pin_sync_i (
    .clk(CLOCK),
    .srst(SRST),
    .en_pin(ENABLE_PIN),
    .pdown_pin(POWER_DOWN_PIN),
    .pins({REGISTER_SELECT_LINE, RD_WR, BUS_LINES[7:4], BUS_LINES[3:0]}),
    .xfer(xfer),
    .pdown(pdown)
  );

  // ------------------------------------------------------------
  // Decode helpers
  // ------------------------------------------------------------
  function automatic logic is_cmd(input logic [7:0] b, input logic [7:0] mask, input logic [7:0] val);
    is_cmd = (b & mask) == val;
  endfunction : is_cmd

  function automatic logic [6:0] step_addr(input logic [6:0] a, input logic inc, input int depth);
    logic [6:0] nxt;
    nxt = inc ? a + 7'h01 : a - 7'h01;
    if (inc && int'(a) >= depth - 1) begin
      nxt = 7'h00;
    end else if (!inc && a == 7'h00) begin
      nxt = 7'(depth - 1);
    end
    step_addr = nxt;
  endfunction : step_addr

  // ------------------------------------------------------------
  // Transfer assembly: byte or nibble pairs
  // ------------------------------------------------------------
  always_comb begin
    cmd_valid = 1'b0;
    cmd_byte = xfer.data;
    cmd_rs = xfer.register_select_line;
    if (xfer.valid && !xfer.rd_wr && r_q.mode == ST_READY) begin
      if (!r_q.nibble_mode) begin
        cmd_valid = 1'b1; // [R01] [R02]
      end else if (r_q.half) begin
        cmd_valid = 1'b1; // [R05]
        cmd_byte = {r_q.upper_held, xfer.data[7:4]}; // [R04]
      end
    end
  end

  // ------------------------------------------------------------
  // Control state
  // ------------------------------------------------------------
  always_comb begin
    r_d = r_q;
    r_d.ack = 1'b0;
    mem_we = 1'b0;
    mem_addr = r_q.addr;
    mem_wdata = cmd_byte;
    mem_glyph = r_q.glyph_sel;
    case (r_q.mode)
      ST_INIT: begin
        // Pin strobes ignored meanwhile; host must wait [R14]
        if (r_q.init_cnt == 16'(INIT_CYCLES - 1)) begin
          r_d.mode = ST_READY;
        end else begin
          r_d.init_cnt = r_q.init_cnt + 16'h0001;
        end
      end
      ST_READY: begin
        if (xfer.valid && r_q.nibble_mode) begin
          r_d.half = ~r_q.half; // [R13]
          if (!r_q.half) begin
            r_d.upper_held = xfer.data[7:4];
          end
        end
        // Snapshot on the upper half so both halves come from one byte
        if (xfer.valid && xfer.rd_wr && r_q.nibble_mode && !r_q.half) begin
          r_d.rd_data = r_q.last_text;
        end
        if (cmd_valid && cmd_rs) begin
          mem_we = 1'b1; // [R09]
          r_d.addr = step_addr(r_q.addr, r_q.cfg.incr, r_q.glyph_sel ? GLYPH_DEPTH : TEXT_DEPTH); // [R08] [R09]
          if (!r_q.glyph_sel) begin
            r_d.last_text = cmd_byte;
          end
        end else if (cmd_valid) begin
          if (is_cmd(cmd_byte, `CMD_TEXT_MASK, `CMD_TEXT_VAL)) begin
            r_d.glyph_sel = 1'b0;
            r_d.addr = cmd_byte[6:0];
          end else if (is_cmd(cmd_byte, `CMD_GLYPH_MASK, `CMD_GLYPH_VAL)) begin
            r_d.glyph_sel = 1'b1;
            r_d.addr = {1'b0, cmd_byte[5:0]};
          end else if (is_cmd(cmd_byte, `CMD_FUNC_MASK, `CMD_FUNC_VAL)) begin
            // Wide bit low selects nibble bus; an eight-line write of 0010 does this [R03]
            r_d.nibble_mode = ~cmd_byte[`FUNC_WIDE_BIT]; // [R06]
            r_d.cfg.two_line = cmd_byte[`FUNC_LINES_BIT]; // [R06]
            r_d.cfg.vreg_sel = cmd_byte[`FUNC_VREG_BIT]; // [R06]
            r_d.cfg.icon_only_select = cmd_byte[`FUNC_ICON_BIT]; // [R10]
            r_d.half = 1'b0;
          end else if (is_cmd(cmd_byte, `CMD_DISP_MASK, `CMD_DISP_VAL)) begin
            r_d.cfg.display_on = cmd_byte[`DISP_ON_BIT]; // [R07] [R11]
            r_d.cfg.cursor_on = cmd_byte[`DISP_CURS_BIT]; // [R07]
          end else if (is_cmd(cmd_byte, `CMD_ENTRY_MASK, `CMD_ENTRY_VAL)) begin
            r_d.cfg.incr = cmd_byte[`ENTRY_INC_BIT]; // [R08]
            r_d.cfg.shift = cmd_byte[`ENTRY_SHIFT_BIT]; // [R08]
          end
        end
        if (cmd_valid) begin
          r_d.first_done = 1'b1;
        end
      end
      ST_PDOWN: begin
        if (!pdown) begin
          r_d.mode = ST_READY;
        end
      end
      default: begin
        r_d.mode = ST_INIT;
      end
    endcase
    // Bus slave: fixed one wait state, answer registered
    if ((AVS_READ || AVS_WRITE) && !r_q.ack) begin
      r_d.ack = 1'b1;
      if (AVS_READ) begin
        // Writes leave the last answer standing
        r_d.readdata = 32'h0000_0000;
        case (AVS_ADDRESS)
          `REG_STAT: begin
            r_d.readdata[`STAT_NIBBLE_BIT] = r_q.nibble_mode;
            r_d.readdata[`STAT_HALF_BIT] = r_q.half;
            r_d.readdata[`STAT_DISP_BIT] = r_q.cfg.display_on;
            r_d.readdata[`STAT_CURS_BIT] = r_q.cfg.cursor_on;
            r_d.readdata[`STAT_ICON_BIT] = r_q.cfg.icon_only_select;
            r_d.readdata[`STAT_PDOWN_BIT] = r_q.mode == ST_PDOWN;
            r_d.readdata[`STAT_BUSY_BIT] = r_q.mode == ST_INIT;
            r_d.readdata[`STAT_INCR_BIT] = r_q.cfg.incr;
            r_d.readdata[`STAT_SHIFT_BIT] = r_q.cfg.shift;
            r_d.readdata[`STAT_GLYPH_BIT] = r_q.glyph_sel;
            r_d.readdata[`STAT_TWOLINE_BIT] = r_q.cfg.two_line;
            r_d.readdata[`STAT_VREG_BIT] = r_q.cfg.vreg_sel;
          end
          `REG_CURS: begin
            r_d.readdata = {16'h0000, r_q.last_text, 1'b0, r_q.addr};
          end
          `REG_INIT: begin
            r_d.readdata = {16'h0000, r_q.init_cnt};
          end
          default: begin
            r_d.readdata = 32'h0000_0000;
          end
        endcase
      end else if (AVS_ADDRESS == `REG_CTRL && AVS_WRITEDATA[`CTRL_INIT_BIT]) begin
        // Software re-initialisation, as reset of the port but last_text, rd_data, upper_held, first_done and readdata kept
        r_d.mode = ST_INIT;
        r_d.init_cnt = 16'h0000;
        r_d.nibble_mode = 1'b0;
        r_d.half = 1'b0;
        r_d.cfg = '0;
        r_d.cfg.incr = 1'b1;
        r_d.glyph_sel = 1'b0;
        r_d.addr = 7'h00;
      end
    end
    // After the bus block so a software re-init cannot lift power-down
    if (pdown) begin
      r_d.mode = ST_PDOWN; // [R12]
    end
    if (SRST) begin
      r_d = '0;
      r_d.mode = ST_INIT; // [R01] [R13]
      r_d.cfg.incr = 1'b1;
    end
  end

  always_ff @(posedge CLOCK) begin
    r_q <= r_d;
  end

  // ------------------------------------------------------------
  // Display and glyph memories
  // ------------------------------------------------------------
  // No reset on arrays: contents are undefined until written
  always_ff @(posedge CLOCK) begin
    if (mem_we && !mem_glyph && int'(mem_addr) < TEXT_DEPTH) begin
      text_mem[mem_addr] <= mem_wdata; // [R09]
    end
    if (mem_we && mem_glyph && int'(mem_addr) < GLYPH_DEPTH) begin
      glyph_mem[mem_addr] <= mem_wdata;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  // Read data: high half first in nibble mode
  always_comb begin
    BUS_LINES_OUT = r_q.last_text;
    BUS_LINES_OE = 8'h00;
    if (RD_WR && ENABLE_PIN && r_q.mode == ST_READY) begin
      BUS_LINES_OE = r_q.nibble_mode ? 8'hf0 : 8'hff;
      if (r_q.nibble_mode) begin
        BUS_LINES_OUT = r_q.half ? {r_q.rd_data[3:0], 4'h0} : {r_q.last_text[7:4], 4'h0};
      end
    end
  end

  assign DISPLAY_ON = r_q.cfg.display_on && r_q.mode == ST_READY; // [R11]
  assign ICON_MODE = r_q.cfg.icon_only_select; // [R10]
  assign POWER_DOWN = r_q.mode == ST_PDOWN; // [R12]
  assign AVS_READDATA = r_q.readdata;
  assign AVS_WAITREQUEST = (AVS_READ || AVS_WRITE) && !r_q.ack;
endmodule : lcd_nibble_bus_init

// ==== lcd_port_monitor.sv ====
// Port checker for the display host port.
// Assumes it is bound to lcd_nibble_bus_init, one clock domain.
`timescale 1ns/100ps
module lcd_port_monitor #(
  parameter int INIT_CYCLES = 20
) (
  input wire logic CLOCK,
  input wire logic SRST,
  input wire logic ENABLE_PIN,
  input wire logic RD_WR,
  input wire logic POWER_DOWN_PIN,
  input wire logic [7:0] BUS_LINES_OE,
  input wire logic DISPLAY_ON,
  input wire logic ICON_MODE,
  input wire logic POWER_DOWN,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_READDATA,
  input wire logic AVS_WAITREQUEST
);
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (SRST);
  wire logic req = AVS_READ || AVS_WRITE;
  logic [7:0] age_q;
  // Saturates so the quiet window is only the first one
  always_ff @(posedge CLOCK) age_q <= SRST ? 8'h00 : (age_q == 8'hff ? age_q : age_q + 8'h01);
  a_wait_one: assert property (req && !$past(req) |-> AVS_WAITREQUEST ##1 !AVS_WAITREQUEST)
    else $error("answer not after one wait state");
  a_init_quiet: assert property (age_q < INIT_CYCLES - 1 |-> BUS_LINES_OE == 8'h00 && !DISPLAY_ON)
    else $error("activity during start-up");
  a_reset_clear: assert property (disable iff (1'b0) SRST |=> !DISPLAY_ON && !ICON_MODE && !POWER_DOWN)
    else $error("outputs not cleared by reset");
  a_pdown_enter: assert property (POWER_DOWN_PIN [*3] |-> ##[0:4] POWER_DOWN)
    else $error("power-down not entered");
  a_pdown_hold: assert property (POWER_DOWN && POWER_DOWN_PIN |=> POWER_DOWN)
    else $error("power-down left while pin high");
  a_disp_pdown: assert property (DISPLAY_ON |-> !POWER_DOWN)
    else $error("display on in power-down");
  a_oe_cause: assert property (BUS_LINES_OE != 8'h00 |-> ENABLE_PIN && RD_WR && !POWER_DOWN)
    else $error("bus driven outside a read");
  a_oe_shape: assert property (BUS_LINES_OE inside {8'h00, 8'hf0, 8'hff})
    else $error("bus enable pattern wrong");
  a_rdata_hold: assert property ($changed(AVS_READDATA) |-> AVS_READ && !AVS_WAITREQUEST)
    else $error("read data moved outside an answer");
  c_pdown: cover property (POWER_DOWN);
  c_read_oe: cover property (BUS_LINES_OE == 8'hf0);
  c_disp: cover property ($rose(DISPLAY_ON));
endmodule : lcd_port_monitor

bind lcd_nibble_bus_init lcd_port_monitor #(.INIT_CYCLES(INIT_CYCLES)) lcd_port_monitor_i (
  .CLOCK(CLOCK), .SRST(SRST), .ENABLE_PIN(ENABLE_PIN), .RD_WR(RD_WR), .POWER_DOWN_PIN(POWER_DOWN_PIN),
  .BUS_LINES_OE(BUS_LINES_OE), .DISPLAY_ON(DISPLAY_ON), .ICON_MODE(ICON_MODE), .POWER_DOWN(POWER_DOWN),
  .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST));

// ==== lcd_host_model.sv ====
// Host microcontroller model driving the parallel pins.
// Assumes tasks are called just after a rising CLOCK edge.
`timescale 1ns/100ps
module lcd_host_model (
  input wire logic CLOCK,
  output logic en,
  output logic rs,
  output logic rw,
  output logic [7:0] lines
);
  logic nib = 1'b0;
  initial begin
    en = 1'b0;
    rs = 1'b0;
    rw = 1'b0;
    lines = 8'h00;
  end
  // Enable high four clocks, then low at least six before the next strobe, above the sync minimum
  task automatic strobe(input logic s, input logic r, input logic [7:0] v);
    rs <= s;
    rw <= r;
    lines <= v;
    @(posedge CLOCK);
    en <= 1'b1;
    repeat (4) @(posedge CLOCK);
    en <= 1'b0;
    repeat (2) @(posedge CLOCK);
    lines <= ~v; // Held time over: lines no longer show the value
    // Extra edge so the applied transfer has settled on return
    repeat (3) @(posedge CLOCK);
  endtask : strobe
  // Lower lines are open in nibble use, so they carry junk
  task automatic xfer(input logic s, input logic [7:0] b);
    if (nib) begin
      strobe(s, 1'b0, {b[7:4], ~lines[3:0]});
      strobe(s, 1'b0, {b[3:0], ~lines[3:0]});
    end else begin
      strobe(s, 1'b0, b);
    end
  endtask : xfer
endmodule : lcd_host_model

// ==== tb_lcd_nibble_bus_init.sv ====
// Self-checking bench for the display host port.
// Assumes the host model and the checker compile first.
`timescale 1ns/100ps
module tb_lcd_nibble_bus_init;
  localparam int INIT = 10;
  logic CLOCK = 1'b0, SRST = 1'b1, POWER_DOWN_PIN = 1'b0, AVS_READ = 1'b0, AVS_WRITE = 1'b0, rd_chk = 1'b0;
  logic [3:0] AVS_ADDRESS = 4'h0;
  logic [31:0] AVS_WRITEDATA = 32'h0, AVS_READDATA, rnd = 32'h421e, ex[$], mk[$];
  logic AVS_WAITREQUEST, DISPLAY_ON, ICON_MODE, POWER_DOWN, en, rs, rw;
  logic [7:0] lines, oe, dout, b, rd_exp;
  wire logic [7:0] bus = (oe & dout) | (~oe & lines);
  int fails = 0, num_checks = 0, cyc = 0, hi = 0;
  lcd_host_model lcd_host_model_i (.CLOCK(CLOCK), .en(en), .rs(rs), .rw(rw), .lines(lines));
  lcd_nibble_bus_init #(.INIT_CYCLES(INIT)) lcd_nibble_bus_init_i (
    .CLOCK(CLOCK), .SRST(SRST), .ENABLE_PIN(en), .REGISTER_SELECT_LINE(rs), .RD_WR(rw), .BUS_LINES(bus),
    .POWER_DOWN_PIN(POWER_DOWN_PIN), .BUS_LINES_OUT(dout), .BUS_LINES_OE(oe), .DISPLAY_ON(DISPLAY_ON),
    .ICON_MODE(ICON_MODE), .POWER_DOWN(POWER_DOWN), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
    .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_READDATA(AVS_READDATA),
    .AVS_WAITREQUEST(AVS_WAITREQUEST));
  initial forever #50 CLOCK = ~CLOCK;
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr
  task automatic stop_test();
    if (fails == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : stop_test
  task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] s);
    num_checks++;
    if (s !== e) begin
      fails++;
      $display("[ERR] %s exp %h got %h", n, e, s);
    end
  endtask : cmp
  // On a read the data argument is the expected word, noted for the watcher
  task automatic av(input logic w, input logic [3:0] a, input logic [31:0] d, input logic [31:0] m);
    @(posedge CLOCK);
    if (!w) begin
      ex.push_back(d);
      mk.push_back(m);
    end
    AVS_ADDRESS <= a;
    AVS_READ <= !w;
    AVS_WRITE <= w;
    AVS_WRITEDATA <= d;
    do @(posedge CLOCK); while (AVS_WAITREQUEST !== 1'b0);
    AVS_READ <= 1'b0;
    AVS_WRITE <= 1'b0;
  endtask : av
  // Watcher: answers take the oldest note; read strobes check the enable
  always @(posedge CLOCK) begin
    cyc <= cyc + 1;
    hi <= en ? hi + 1 : 0;
    if (AVS_READ === 1'b1 && AVS_WAITREQUEST === 1'b0 && ex.size() > 0) begin
      cmp("readdata", ex[0] & mk[0], AVS_READDATA & mk[0]); // tag at the av call
      void'(ex.pop_front());
      void'(mk.pop_front());
    end
    if (rd_chk && en === 1'b1 && hi >= 2) begin
      cmp("bus_oe", 32'hf0, {24'h0, oe});
      cmp("bus_out", {24'h0, rd_exp}, {24'h0, dout});
    end
    if (cyc == 20000) begin
      fails++;
      stop_test();
    end
  end
  initial begin
    repeat (3) @(posedge CLOCK);
    SRST <= 1'b0;
    repeat (INIT + 4) @(posedge CLOCK);
    av(1'b0, 4'h4, 32'h080, 32'hfff);
    av(1'b0, 4'h2, 32'h0, 32'hffffffff);
    lcd_host_model_i.xfer(1'b0, 8'h22);
    av(1'b0, 4'h4, 32'h091, 32'hfff);
    lcd_host_model_i.nib = 1'b1;
    lcd_host_model_i.xfer(1'b0, 8'h20);
    av(1'b0, 4'h4, 32'h081, 32'hfff);
    cmp("icon", 32'h0, {31'h0, ICON_MODE});
    lcd_host_model_i.strobe(1'b0, 1'b0, 8'h05);
    av(1'b0, 4'h4, 32'h083, 32'hfff);
    lcd_host_model_i.strobe(1'b0, 1'b0, 8'he5);
    av(1'b0, 4'h4, 32'h08d, 32'hfff);
    cmp("display", 32'h1, {31'h0, DISPLAY_ON});
    lcd_host_model_i.xfer(1'b0, 8'h05);
    av(1'b0, 4'h4, 32'h10d, 32'hfff);
    lcd_host_model_i.xfer(1'b0, 8'h06);
    av(1'b0, 4'h4, 32'h08d, 32'hfff);
    for (int i = 1; i <= 3; i++) begin
      b = rnd[7:0];
      rnd = lfsr(rnd);
      lcd_host_model_i.xfer(1'b1, b);
      av(1'b0, 4'h8, {16'h0, b, 8'(i)}, 32'hffff);
    end
    rd_chk = 1'b1;
    rd_exp = {b[7:4], 4'h0};
    lcd_host_model_i.strobe(1'b0, 1'b1, 8'h00);
    rd_exp = {b[3:0], 4'h0};
    lcd_host_model_i.strobe(1'b0, 1'b1, 8'h00);
    rd_chk = 1'b0;
    av(1'b0, 4'h4, 32'h08d, 32'hfff);
    lcd_host_model_i.xfer(1'b0, 8'h22);
    cmp("icon", 32'h1, {31'h0, ICON_MODE});
    lcd_host_model_i.xfer(1'b0, 8'h08);
    cmp("display", 32'h0, {31'h0, DISPLAY_ON});
    lcd_host_model_i.xfer(1'b0, 8'h0c);
    POWER_DOWN_PIN <= 1'b1;
    lcd_host_model_i.xfer(1'b0, 8'h08);
    cmp("pdown", 32'h1, {31'h0, POWER_DOWN});
    cmp("display", 32'h0, {31'h0, DISPLAY_ON});
    POWER_DOWN_PIN <= 1'b0;
    repeat (6) @(posedge CLOCK);
    cmp("pdown", 32'h0, {31'h0, POWER_DOWN});
    av(1'b0, 4'h4, 32'h004, 32'h004);
    av(1'b1, 4'h0, 32'h1, 32'h0);
    av(1'b0, 4'h4, 32'h040, 32'h040);
    repeat (INIT + 4) @(posedge CLOCK);
    av(1'b0, 4'h4, 32'h000, 32'h041);
    stop_test();
  end
endmodule : tb_lcd_nibble_bus_init
